/* File: core/ppei_pkg.sv */
`default_nettype none
// ---------------------------------------------------------------------------
// Shared constants for the port pin edge interrupt and I/O block.
// ---------------------------------------------------------------------------
package ppei_pkg;
    // Register indices as printed; the byte address is four times the index.
    localparam logic [7:0] IDX_PULL_ENABLE_P  = 8'h1C;
    localparam logic [7:0] IDX_POLARITY_P     = 8'h1D;
    localparam logic [7:0] IDX_IRQ_ENABLE_P   = 8'h1E;
    localparam logic [7:0] IDX_EDGE_FLAGS_P   = 8'h1F;
    localparam logic [7:0] IDX_J_DATA         = 8'h28;
    localparam logic [7:0] IDX_J_PIN_INPUT    = 8'h29;
    localparam logic [7:0] IDX_J_DIRECTION    = 8'h2A;
    localparam logic [7:0] IDX_J_DRIVE        = 8'h2B;
    // Extra registers for the interrupt status and mask.
    localparam logic [7:0] IDX_IRQ_STATUS     = 8'h40;
    localparam logic [7:0] IDX_IRQ_MASK       = 8'h41;
    // Port J implements bits 7 and 6 only.
    localparam int         J_LSB              = 6;
    localparam int         J_WIDTH            = 2;
    // Values after reset.
    localparam logic [7:0] RST_BYTE           = 8'h00;
    localparam logic [1:0] RST_J              = 2'h0;
    // Interrupt status bit positions.
    localparam int         ST_EDGE            = 0;
    localparam int         ST_DIR             = 1;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY          = 2'h0;
    localparam logic [1:0] RESP_SLVERR        = 2'h2;
    // Synchroniser length in bus cycles.
    localparam int         SYNC_STAGES        = 2;
endpackage : ppei_pkg
`default_nettype wire

/* File: core/ppei_sync.sv */
`default_nettype none
// ---------------------------------------------------------------------------
// Two-stage synchroniser for a bus of pin levels.
// ---------------------------------------------------------------------------
module ppei_sync
    import ppei_pkg::*;
#(
    parameter int W = 10
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ppei_sync_s;

    ppei_sync_s st;
    ppei_sync_s next_st;

    // The first stage feeds only the second stage.
    always_comb begin
        next_st.meta   = async_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_out = st.stable;
endmodule : ppei_sync
`default_nettype wire

/* File: core/ppei_top.sv */
// The AXI4-Lite slave port was chosen for this implementation.
`default_nettype none
module ppei_top
    import ppei_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        RST,
    // AXI4-Lite slave.
    input  wire logic [31:0] S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [31:0] S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // Port P pins, inputs only in this block.
    input  wire logic [7:0]  P_PIN_IN,
    output logic [7:0]       P_PULL_ON,
    output logic [7:0]       P_PULL_UP,
    output logic             P_IRQ,
    // Port J pins 7:6.
    input  wire logic [1:0]  J_PIN_IN,
    output logic [1:0]       J_PIN_OUT,
    output logic [1:0]       J_PIN_OE,
    output logic [1:0]       J_REDUCED_DRIVE,
    // Summary interrupt.
    output logic             IRQ
);
    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------
    // Everything the block remembers, bar the pin synchroniser stages, lives in one struct, so reset is one
    // statement and the next value is built in one place; the bus channel
    // holders come first, then the software-visible registers, then the
    // flops that feed the pads directly.
    typedef struct packed {
        logic [31:0] aw_addr;
        logic        aw_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        w_held;
        logic        b_valid;
        logic [1:0]  b_resp;
        logic        r_valid;
        logic [31:0] r_data;
        logic [1:0]  r_resp;
        logic [7:0]  pull_enable_p;
        logic [7:0]  polarity_p;
        logic [7:0]  irq_enable_p;
        logic [7:0]  edge_flags_p;
        logic [7:0]  p_prev;
        logic [1:0]  j_data;
        logic [1:0]  j_direction;
        logic [1:0]  j_drive;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic [7:0]  pull_up_p;
        logic [1:0]  j_reduced;
    } ppei_s;

    // Present state and the value it takes at the next edge.
    ppei_s st;
    ppei_s next_st;

    // Synchronised pin levels: port P in the low byte, port J above it.
    logic [9:0] pins_sync;
    logic [7:0] p_sync;
    logic [1:0] j_sync;

    // -----------------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------------
    // Port J rides in the top two bits of the shared synchroniser, so both
    // ports see the same two-edge latency from pin to logic, and nothing
    // reads a pin before it has passed both stages.
    ppei_sync #(
        .W (10)
    ) u_sync (
        .clk      (CLOCK),
        .rst      (RST),
        .async_in ({J_PIN_IN, P_PIN_IN}),
        .sync_out (pins_sync)
    );

    assign p_sync = pins_sync[7:0];
    assign j_sync = pins_sync[9:8];

    // True when a byte address falls on the word of register idx; the two
    // low address bits are ignored, as every register is one aligned word.
    function automatic logic addr_hit(input logic [31:0] a, input logic [7:0] idx);
        addr_hit = (a[31:2] == {22'h000000, idx});
    endfunction : addr_hit

    // Merges a write byte into a register under the lane-0 strobe. Lanes 1
    // to 3 carry nothing, as every register here is one byte wide.
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
        lane0 = s[0] ? d[7:0] : old;
    endfunction : lane0

    // -----------------------------------------------------------------------
    // Edge detection and readback
    // -----------------------------------------------------------------------
    logic        wr_fire;
    logic        rd_fire;
    logic [7:0]  edge_hit;
    logic [7:0]  w1c_mask;
    logic [31:0] rd_word;
    logic        rd_ok;
    logic        wr_ok;
    logic [1:0]  j_read;
    logic [1:0]  ev;

    // One detector per pin compares the synchronised level with the level
    // held one edge earlier, so a pin change can set its flag once only.
    for (genvar g = 0; g < 8; g++) begin : g_edge
        // Polarity 0 catches a fall and polarity 1 a rise; the enable plays
        // no part in setting the flag.
        assign edge_hit[g] = st.polarity_p[g] ? (p_sync[g] && !st.p_prev[g])
                                              : (!p_sync[g] && st.p_prev[g]);
    end

    // Port J data reads the latch on output pins and the synchronised pin on
    // inputs; the pin stages make readback lag a direction change by up to
    // two edges.
    for (genvar k = 0; k < J_WIDTH; k++) begin : g_jread
        assign j_read[k] = st.j_direction[k] ? st.j_data[k] : j_sync[k];
    end

    // -----------------------------------------------------------------------
    // Register logic
    // -----------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.p_prev = p_sync;

        // A write goes ahead once address and data are both held and no
        // response is waiting; the two may arrive in either order.
        wr_fire = st.aw_held && st.w_held && !st.b_valid;
        rd_fire = S_AXI_ARVALID && !st.r_valid;

        // Each channel is captured on its own handshake and kept until the
        // write is performed; ready stays low meanwhile, so nothing is lost.
        if (S_AXI_AWVALID && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.w_data = S_AXI_WDATA;
            next_st.w_strb = S_AXI_WSTRB;
        end

        // Register writes act on lane 0 only. An address off the map falls
        // to the last branch, is answered with an error and changes nothing,
        // so a stray write can never disturb a real register.
        w1c_mask = 8'h00;
        wr_ok    = 1'b0;
        ev       = 2'h0;
        if (wr_fire) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.b_valid = 1'b1;
            wr_ok = 1'b1;
            if (addr_hit(st.aw_addr, IDX_PULL_ENABLE_P)) begin
                next_st.pull_enable_p = lane0(st.pull_enable_p, st.w_data, st.w_strb);
            end else if (addr_hit(st.aw_addr, IDX_POLARITY_P)) begin
                next_st.polarity_p = lane0(st.polarity_p, st.w_data, st.w_strb);
            end else if (addr_hit(st.aw_addr, IDX_IRQ_ENABLE_P)) begin
                next_st.irq_enable_p = lane0(st.irq_enable_p, st.w_data, st.w_strb);
            end else if (addr_hit(st.aw_addr, IDX_EDGE_FLAGS_P)) begin
                w1c_mask = st.w_strb[0] ? st.w_data[7:0] : 8'h00;
            end else if (addr_hit(st.aw_addr, IDX_J_DATA)) begin
                // Only pins 7 and 6 exist; the other bits of the byte are dropped.
                if (st.w_strb[0]) begin
                    next_st.j_data = st.w_data[J_LSB +: J_WIDTH];
                end
            end else if (addr_hit(st.aw_addr, IDX_J_PIN_INPUT)) begin
                // Read-only: the write is answered but changes nothing.
            end else if (addr_hit(st.aw_addr, IDX_J_DIRECTION)) begin
                // Turning any pin round is recorded as a status event.
                if (st.w_strb[0]) begin
                    next_st.j_direction = st.w_data[J_LSB +: J_WIDTH];
                    ev[ST_DIR] = (st.w_data[J_LSB +: J_WIDTH] != st.j_direction);
                end
            end else if (addr_hit(st.aw_addr, IDX_J_DRIVE)) begin
                if (st.w_strb[0]) begin
                    next_st.j_drive = st.w_data[J_LSB +: J_WIDTH];
                end
            end else if (addr_hit(st.aw_addr, IDX_IRQ_STATUS)) begin
                // Status is cleared by reading, not writing.
            end else if (addr_hit(st.aw_addr, IDX_IRQ_MASK)) begin
                if (st.w_strb[0]) begin
                    next_st.irq_mask = st.w_data[1:0];
                end
            end else begin
                wr_ok = 1'b0;
            end
            next_st.b_resp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        // The write response stands until the master takes it.
        if (st.b_valid && S_AXI_BREADY) begin
            next_st.b_valid = 1'b0;
        end

        // A new edge wins over a clear landing in the same cycle.
        next_st.edge_flags_p = (st.edge_flags_p & ~w1c_mask) | edge_hit;
        ev[ST_EDGE] = |edge_hit;

        // Pull sense and reduced drive are registered from the values being
        // written, so the pad controls come straight from flops and change
        // at the same edge as the register behind them.
        next_st.pull_up_p = ~next_st.polarity_p;
        next_st.j_reduced = next_st.j_drive & next_st.j_direction;

        // The read word is decoded from the address as it stands on the bus;
        // the master holds it until ARREADY, so the decode sees it steady.
        rd_word = 32'h00000000;
        rd_ok   = 1'b1;
        if (addr_hit(S_AXI_ARADDR, IDX_PULL_ENABLE_P)) begin
            rd_word[7:0] = st.pull_enable_p;
        end else if (addr_hit(S_AXI_ARADDR, IDX_POLARITY_P)) begin
            rd_word[7:0] = st.polarity_p;
        end else if (addr_hit(S_AXI_ARADDR, IDX_IRQ_ENABLE_P)) begin
            rd_word[7:0] = st.irq_enable_p;
        end else if (addr_hit(S_AXI_ARADDR, IDX_EDGE_FLAGS_P)) begin
            rd_word[7:0] = st.edge_flags_p;
        end else if (addr_hit(S_AXI_ARADDR, IDX_J_DATA)) begin
            rd_word[J_LSB +: J_WIDTH] = j_read;
        end else if (addr_hit(S_AXI_ARADDR, IDX_J_PIN_INPUT)) begin
            rd_word[J_LSB +: J_WIDTH] = j_sync;
        end else if (addr_hit(S_AXI_ARADDR, IDX_J_DIRECTION)) begin
            rd_word[J_LSB +: J_WIDTH] = st.j_direction;
        end else if (addr_hit(S_AXI_ARADDR, IDX_J_DRIVE)) begin
            rd_word[J_LSB +: J_WIDTH] = st.j_drive;
        end else if (addr_hit(S_AXI_ARADDR, IDX_IRQ_STATUS)) begin
            rd_word[1:0] = st.irq_status;
        end else if (addr_hit(S_AXI_ARADDR, IDX_IRQ_MASK)) begin
            rd_word[1:0] = st.irq_mask;
        end else begin
            rd_ok = 1'b0;
        end

        // Sticky status: bit 0 records any flag being set and bit 1 a write
        // that turned a port J pin round. Reading the word hands the events
        // back and clears them, but an event in the same cycle stays.
        next_st.irq_status = st.irq_status | ev;
        if (rd_fire) begin
            next_st.r_valid = 1'b1;
            next_st.r_data  = rd_word;
            next_st.r_resp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
            if (addr_hit(S_AXI_ARADDR, IDX_IRQ_STATUS)) begin
                next_st.irq_status = ev;
            end
        end
        // Read data stand until the master takes them.
        if (st.r_valid && S_AXI_RREADY) begin
            next_st.r_valid = 1'b0;
        end
    end

    // -----------------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------------
    // Synchronous reset clears every field but pull_up_p, which loads all ones; the named fields restate their
    // reset constants so the values after reset sit together here.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            st               <= '0;
            st.pull_enable_p <= RST_BYTE;
            st.polarity_p    <= RST_BYTE;
            st.irq_enable_p  <= RST_BYTE;
            st.edge_flags_p  <= RST_BYTE;
            st.j_direction   <= RST_J;
            st.b_resp        <= RESP_OKAY;
            st.r_resp        <= RESP_OKAY;
            st.pull_up_p     <= ~RST_BYTE;
            st.j_reduced     <= RST_J;
        end else begin
            st <= next_st;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    // Handshake outputs are plain decodes of the held flags; every data
    // output comes straight from a flop.
    // Ready is withheld while a channel already holds an item.
    assign S_AXI_AWREADY = !st.aw_held;
    assign S_AXI_WREADY  = !st.w_held;
    assign S_AXI_BVALID  = st.b_valid;
    assign S_AXI_BRESP   = st.b_resp;
    assign S_AXI_ARREADY = !st.r_valid;
    assign S_AXI_RVALID  = st.r_valid;
    assign S_AXI_RDATA   = st.r_data;
    assign S_AXI_RRESP   = st.r_resp;

    // Port P pins are inputs here, so the pull enable alone gates the pull;
    // polarity 0 picks pull-up and 1 pull-down.
    assign P_PULL_ON = st.pull_enable_p;
    assign P_PULL_UP = st.pull_up_p;

    // Flags gated by their enables form the port request; a flag whose
    // enable is 0 stays readable but stays out of the request.
    assign P_IRQ = |(st.edge_flags_p & st.irq_enable_p);

    // Direction drives the enable; drive select only matters on outputs.
    // The latch drives the pad even while the pin is an input, so turning a
    // pin round shows the latched level at once.
    assign J_PIN_OUT       = st.j_data;
    assign J_PIN_OE        = st.j_direction;
    assign J_REDUCED_DRIVE = st.j_reduced;

    // Summary interrupt from sticky status under its mask; it stays high
    // until the status word is read.
    assign IRQ = |(st.irq_status & st.irq_mask);
endmodule : ppei_top
`default_nettype wire

/* File: testbench/ppei_pins.sv */
`default_nettype none
// ----------
// Board side of the port pins.
// ----------
module ppei_pins (
    input  wire logic       clk,
    input  wire logic [7:0] p_ext,
    input  wire logic [7:0] p_flt,
    input  wire logic [7:0] pull_on,
    input  wire logic [7:0] pull_up,
    output logic      [7:0] p_pin,
    input  wire logic [1:0] j_ext,
    input  wire logic [1:0] j_short,
    input  wire logic [1:0] j_out,
    input  wire logic [1:0] j_oe,
    output logic      [1:0] j_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wob = 8'h55;
    // A floating pin without a pull wobbles, so no stale level can pass for a real one.
    always @(posedge clk) wob <= ~wob;
    // A shorted output shows the board level, as a real overload would.
    always_comb begin
        p_pin = (p_ext & ~p_flt) | (p_flt & ((pull_on & pull_up) | (~pull_on & wob)));
        j_pin = (j_oe & ~j_short & j_out) | (~(j_oe & ~j_short) & j_ext);
    end
endmodule : ppei_pins
`default_nettype wire

/* File: testbench/ppei_top_asserts.sv */
`default_nettype none
// ----------
// Port-level checks.
// ----------
module ppei_top_asserts (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        S_AXI_RREADY,
    input wire logic [7:0]  P_PIN_IN,
    input wire logic [7:0]  P_PULL_ON,
    input wire logic        P_IRQ,
    input wire logic [1:0]  J_PIN_OE,
    input wire logic [1:0]  J_REDUCED_DRIVE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking ck @(posedge CLOCK); endclocking
    default disable iff (RST);
    logic [7:0] p_prev;
    logic [3:0] quiet;
    // Age of the last pin change; a flag may only follow a fresh one.
    always_ff @(posedge CLOCK) begin
        p_prev <= P_PIN_IN;
        if (RST || P_PIN_IN != p_prev) quiet <= 4'h0;
        else if (quiet != 4'hF) quiet <= quiet + 4'h1;
    end
    sequence wr_done;
        $rose(S_AXI_BVALID);
    endsequence
    sequence pin_fresh;
        quiet <= 4'h4;
    endsequence
    b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
    rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered");
    r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
    irq_rise_a: assert property ($rose(P_IRQ) |-> pin_fresh or wr_done)
        else $error("port interrupt rose without cause");
    irq_fall_a: assert property ($fell(P_IRQ) |-> wr_done)
        else $error("port interrupt fell without a write");
    drive_gate_a: assert property ((J_REDUCED_DRIVE & ~J_PIN_OE) == 2'h0)
        else $error("reduced drive on an input");
    dir_cause_a: assert property ($changed(J_PIN_OE) |-> wr_done)
        else $error("direction changed without a write");
    pull_reset_a: assert property ($fell(RST) |-> P_PULL_ON == 8'h00 && !P_IRQ)
        else $error("pull or interrupt on after reset");
endmodule : ppei_top_asserts
bind ppei_top ppei_top_asserts chk_u (.CLOCK, .RST, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY, .P_PIN_IN,
    .P_PULL_ON, .P_IRQ, .J_PIN_OE, .J_REDUCED_DRIVE);
`default_nettype wire

/* File: testbench/port_pin_edge_irq_io_tb_top.sv */
`default_nettype none
// ----------
// Self-checking bench.
// ----------
module port_pin_edge_irq_io_tb_top import ppei_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, rst = 1'b1;
    logic        aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic [31:0] aw_a = 32'h0, w_d = 32'h0, ar_a = 32'h0, rdata, seed = 32'h0000EA9B;
    logic [7:0]  p_ext = 8'h00, p_flt = 8'h00, p_pin, pull_on, pull_up;
    logic [1:0]  j_ext = 2'h0, j_short = 2'h0, j_pin, j_out, j_oe, j_rd, bresp, rresp;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v, p_irq, irq;
    int          bad_count = 0, n_compared = 0, cyc = 0;
    logic [7:0]  ridx [10] = '{IDX_PULL_ENABLE_P, IDX_POLARITY_P, IDX_IRQ_ENABLE_P,
        IDX_EDGE_FLAGS_P, IDX_J_DATA, IDX_J_PIN_INPUT, IDX_J_DIRECTION, IDX_J_DRIVE,
        IDX_IRQ_STATUS, IDX_IRQ_MASK};
    always #4 clk = ~clk;
    ppei_top dut_u (.CLOCK(clk), .RST(rst), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v),
        .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v),
        .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(b_v), .S_AXI_BREADY(b_r),
        .S_AXI_ARADDR(ar_a), .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(ar_rdy), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(r_v), .S_AXI_RREADY(r_r), .P_PIN_IN(p_pin),
        .P_PULL_ON(pull_on), .P_PULL_UP(pull_up), .P_IRQ(p_irq), .J_PIN_IN(j_pin),
        .J_PIN_OUT(j_out), .J_PIN_OE(j_oe), .J_REDUCED_DRIVE(j_rd), .IRQ(irq));
    ppei_pins pins_u (.clk(clk), .p_ext(p_ext), .p_flt(p_flt), .pull_on(pull_on),
        .pull_up(pull_up), .p_pin(p_pin), .j_ext(j_ext), .j_short(j_short), .j_out(j_out),
        .j_oe(j_oe), .j_pin(j_pin));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    // Xorshift step; the fixed seed makes every run draw the same values.
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    // Flags expected from one change of the pin levels.
    function automatic logic [7:0] edge_exp(input logic [7:0] pol, a, b);
        return (pol & ~a & b) | (~pol & a & ~b);
    endfunction : edge_exp
    // Ready is raised only once the answer shows, so the hold rules get exercised.
    task automatic wreg(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
        aw_a <= {22'h0, i, 2'h0};
        w_d <= {24'h0, d};
        aw_v <= 1'b1;
        w_v <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_v && aw_rdy) aw_v <= 1'b0;
            if (w_v && w_rdy) w_v <= 1'b0;
            if (b_v && !b_r) b_r <= 1'b1;
        end while (!(b_v && b_r));
        chk({30'h0, bresp}, {30'h0, er});
        b_r <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er);
        ar_a <= {22'h0, i, 2'h0};
        ar_v <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_v && ar_rdy) ar_v <= 1'b0;
            if (r_v && !r_r) r_r <= 1'b1;
        end while (!(r_v && r_r));
        chk(rdata, {24'h0, e});
        chk({30'h0, rresp}, {30'h0, er});
        r_r <= 1'b0;
    endtask : rreg
    // Hang guard; the run needs under a thousand cycles.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        logic [7:0] pol, a, b, m, f, fl, dir, dat;
        logic [1:0] pin, drv;
        a = 8'h00;
        dir = 8'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        foreach (ridx[k]) rreg(ridx[k], 8'h00, RESP_OKAY);
        chk({24'h0, pull_up}, 32'hFF);
        rreg(8'hFF, 8'h00, RESP_SLVERR);
        wreg(8'hFF, 8'h5A, RESP_SLVERR);
        // Edges under random polarity and pulls; the first two pass all rise, then all fall.
        for (int i = 0; i < 16; i++) begin
            pol = rnd();
            m = rnd();
            b = rnd();
            f = rnd();
            if (i < 2) begin
                pol = i[0] ? 8'h00 : 8'hFF;
                b = pol;
                f = 8'h00;
            end
            p_flt <= 8'h00;
            p_ext <= a;
            wreg(IDX_POLARITY_P, pol, RESP_OKAY);
            wreg(IDX_PULL_ENABLE_P, m, RESP_OKAY);
            wreg(IDX_IRQ_ENABLE_P, 8'h00, RESP_OKAY);
            chk({24'h0, pull_on}, {24'h0, m});
            chk({24'h0, pull_up}, {24'h0, ~pol});
            f = f & m;
            p_ext <= b;
            p_flt <= f;
            b = (b & ~f) | (~pol & f);
            repeat (6) @(posedge clk);
            fl = edge_exp(pol, a, b);
            rreg(IDX_EDGE_FLAGS_P, fl, RESP_OKAY);
            chk({31'h0, p_irq}, 32'h0);
            wreg(IDX_IRQ_ENABLE_P, m, RESP_OKAY);
            chk({31'h0, p_irq}, {31'h0, |(fl & m)});
            f = rnd();
            wreg(IDX_EDGE_FLAGS_P, f, RESP_OKAY);
            rreg(IDX_EDGE_FLAGS_P, fl & ~f, RESP_OKAY);
            chk({31'h0, p_irq}, {31'h0, |(fl & ~f & m)});
            wreg(IDX_EDGE_FLAGS_P, 8'hFF, RESP_OKAY);
            a = b;
        end
        // Port J readback, with shorted outputs and an ignored write to the input word.
        for (int i = 0; i < 8; i++) begin
            m = rnd();
            dat = rnd();
            b = rnd();
            dir = (dir ^ (m | 8'h40)) & 8'hC0;
            j_ext <= b[1:0];
            j_short <= b[3:2];
            wreg(IDX_J_DATA, dat, RESP_OKAY);
            wreg(IDX_J_DIRECTION, dir, RESP_OKAY);
            wreg(IDX_J_DRIVE, m, RESP_OKAY);
            wreg(IDX_J_PIN_INPUT, ~b, RESP_OKAY);
            repeat (2) @(posedge clk);
            drv = dir[7:6] & ~b[3:2];
            pin = (drv & dat[7:6]) | (~drv & b[1:0]);
            rreg(IDX_J_PIN_INPUT, {pin, 6'h00}, RESP_OKAY);
            rreg(IDX_J_DATA, {(dir[7:6] & dat[7:6]) | (~dir[7:6] & pin), 6'h00}, RESP_OKAY);
            rreg(IDX_J_DIRECTION, dir, RESP_OKAY);
            rreg(IDX_J_DRIVE, m & 8'hC0, RESP_OKAY);
            chk({30'h0, j_oe}, {30'h0, dir[7:6]});
            chk({30'h0, j_rd}, {30'h0, m[7:6] & dir[7:6]});
            chk({30'h0, j_out}, {30'h0, dat[7:6]});
        end
        // Summary interrupt held back by the mask, then cleared by reading status.
        chk({31'h0, irq}, 32'h0);
        wreg(IDX_IRQ_MASK, 8'h03, RESP_OKAY);
        rreg(IDX_IRQ_MASK, 8'h03, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        rreg(IDX_IRQ_STATUS, 8'h03, RESP_OKAY);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        test_done();
    end
endmodule : port_pin_edge_irq_io_tb_top
`default_nettype wire
